// file: src/erw_consts.svh
// register offsets, field positions, reset values and timing counts of the ready wait control
`ifndef ERW_CONSTS_SVH
`define ERW_CONSTS_SVH

`define ERW_OFS_CFG 12'h000
`define ERW_OFS_STAT 12'h004
`define ERW_OFS_RDATA 12'h008

`define ERW_CFG_POL_BIT 0
`define ERW_CFG_ASYNC_BIT 1
`define ERW_CFG_RDYEN_BIT 2
`define ERW_CFG_MWAIT_LSB 4
`define ERW_CFG_MWAIT_MSB 7

`define ERW_STAT_BUSY_BIT 0
`define ERW_STAT_WCNT_LSB 8
`define ERW_STAT_WCNT_MSB 15
`define ERW_STAT_CCNT_LSB 16
`define ERW_STAT_CCNT_MSB 31

`define ERW_CFG_RESET 32'h0000_0011

// bus reference clock is clk_sys divided by this many cycles
`define ERW_REF_DIV 2

`endif

// file: src/erw_pkg.sv
// types shared by the ready wait control design
package erw_pkg;

  typedef enum logic [4:0] {
    ERW_IDLE = 5'b00001,
    ERW_ADDR = 5'b00010,
    ERW_CMD = 5'b00100,
    ERW_DONE = 5'b01000,
    ERW_ACK = 5'b10000
  } erw_state_t;

  // per-cycle ready configuration
  typedef struct packed {
    logic pol_high;
    logic async_mode;
    logic ready_en;
    logic [3:0] mand_waits;
  } erw_cfg_t;

endpackage

// file: src/erw_ready_ctrl.sv
// external bus cycle engine with ready-controlled wait states and apb configuration
//
// Design decisions made here: the APB slave port and the address map.
`include "erw_consts.svh"
module erw_ready_ctrl
  import erw_pkg::*;
#(
  parameter int AW = 24,
  parameter int DW = 16
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ack,
  output logic [DW-1:0] req_rdata,
  output logic bus_reference_clock,
  output logic [AW-1:0] ext_addr,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic [DW-1:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [DW-1:0] ext_data_in,
  input wire logic ext_ready
);

  typedef struct packed {
    erw_state_t state;
    logic refclk;
    erw_cfg_t cfg;
    erw_cfg_t cyc_cfg;
    logic [3:0] mcnt;
    logic first_wait;
    logic [7:0] wcnt;
    logic [7:0] last_wcnt;
    logic [15:0] ccnt;
    logic rdy_async;
    logic cyc_write;
    logic [AW-1:0] addr;
    logic rd_n;
    logic wr_n;
    logic [DW-1:0] dout;
    logic doe;
    logic [DW-1:0] rdata;
    logic ack;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } erw_st_t;

  erw_st_t st_reg;
  erw_st_t st_next;
  logic rdy_pin;
  logic tick;
  logic rdy_level;
  logic rdy_active;
  logic apb_acc;
  logic [31:0] cfg_word;
  localparam logic [31:0] CFG_RST = `ERW_CFG_RESET; // reset word of the config register

  // pin synchroniser for ready
  erw_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(ext_ready),
    .dout(rdy_pin)
  );

  // phase boundary: edge where the reference clock falls
  assign tick = st_reg.refclk;

  // sample point per mode, polarity applied from the held cycle config
  always_comb
  begin
    rdy_level = st_reg.cyc_cfg.async_mode ? st_reg.rdy_async : rdy_pin;
    rdy_active = (rdy_level == st_reg.cyc_cfg.pol_high);
    apb_acc = psel && penable && !st_reg.pready;
    cfg_word = '0;
    cfg_word[`ERW_CFG_POL_BIT] = st_reg.cfg.pol_high;
    cfg_word[`ERW_CFG_ASYNC_BIT] = st_reg.cfg.async_mode;
    cfg_word[`ERW_CFG_RDYEN_BIT] = st_reg.cfg.ready_en;
    cfg_word[`ERW_CFG_MWAIT_MSB:`ERW_CFG_MWAIT_LSB] = st_reg.cfg.mand_waits;
  end

  // next-state logic for bus cycle and apb slave
  always_comb
  begin
    st_next = st_reg;
    st_next.refclk = ~st_reg.refclk;
    st_next.rdy_async = rdy_pin;
    st_next.ack = 1'b0;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;

    unique case (st_reg.state)
      ERW_IDLE:
      begin
        if (req_valid && tick)
        begin
          st_next.cyc_cfg = st_reg.cfg;
          st_next.cyc_write = req_write;
          st_next.addr = req_addr;
          st_next.dout = req_wdata;
          st_next.doe = req_write;
          st_next.state = ERW_ADDR;
        end
      end
      ERW_ADDR:
      begin
        if (tick)
        begin
          st_next.rd_n = st_reg.cyc_write;
          st_next.wr_n = !st_reg.cyc_write;
          st_next.mcnt = st_reg.cyc_cfg.mand_waits;
          st_next.first_wait = st_reg.cyc_cfg.async_mode;
          st_next.wcnt = '0;
          st_next.state = ERW_CMD;
        end
      end
      ERW_CMD:
      begin
        if (tick)
        begin
          if (st_reg.mcnt != 4'h0)
          begin
            st_next.mcnt = st_reg.mcnt - 4'h1;
          end
          else if (st_reg.cyc_cfg.ready_en && (st_reg.first_wait || !rdy_active))
          begin
            st_next.first_wait = 1'b0;
            st_next.wcnt = st_reg.wcnt + 8'h01;
          end
          else
          begin
            // end of cycle: strobe rises, address moves, read data taken
            st_next.rd_n = 1'b1;
            st_next.wr_n = 1'b1;
            st_next.addr = '0;
            if (!st_reg.cyc_write)
            begin
              st_next.rdata = ext_data_in;
            end
            st_next.last_wcnt = st_reg.wcnt;
            st_next.ccnt = st_reg.ccnt + 16'h0001;
            st_next.state = ERW_DONE;
          end
        end
      end
      ERW_DONE:
      begin
        st_next.doe = 1'b0;
        st_next.ack = 1'b1;
        st_next.state = ERW_ACK;
      end
      ERW_ACK:
      begin
        st_next.state = ERW_IDLE;
      end
      default:
      begin
        st_next.state = ERW_IDLE;
      end
    endcase

    // apb slave: one wait cycle, registered answer
    if (apb_acc)
    begin
      st_next.pready = 1'b1;
      st_next.prdata = '0;
      unique case (paddr)
        `ERW_OFS_CFG:
        begin
          if (!pwrite)
          begin
            st_next.prdata = cfg_word;
          end
        end
        `ERW_OFS_STAT:
        begin
          st_next.prdata[`ERW_STAT_BUSY_BIT] = (st_reg.state != ERW_IDLE);
          st_next.prdata[`ERW_STAT_WCNT_MSB:`ERW_STAT_WCNT_LSB] = st_reg.last_wcnt;
          st_next.prdata[`ERW_STAT_CCNT_MSB:`ERW_STAT_CCNT_LSB] = st_reg.ccnt;
          st_next.pslverr = pwrite;
        end
        `ERW_OFS_RDATA:
        begin
          st_next.prdata[DW-1:0] = st_reg.rdata;
          st_next.pslverr = pwrite;
        end
        default:
        begin
          st_next.pslverr = 1'b1; // unmapped
        end
      endcase
    end

    // config write lands on the edge where the master sees pready
    if (psel && penable && pwrite && st_reg.pready && (paddr == `ERW_OFS_CFG))
    begin
      st_next.cfg.pol_high = pwdata[`ERW_CFG_POL_BIT];
      st_next.cfg.async_mode = pwdata[`ERW_CFG_ASYNC_BIT];
      st_next.cfg.ready_en = pwdata[`ERW_CFG_RDYEN_BIT];
      st_next.cfg.mand_waits = pwdata[`ERW_CFG_MWAIT_MSB:`ERW_CFG_MWAIT_LSB];
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
      st_reg.state <= ERW_IDLE;
      st_reg.cfg.pol_high <= CFG_RST[`ERW_CFG_POL_BIT];
      st_reg.cfg.async_mode <= CFG_RST[`ERW_CFG_ASYNC_BIT];
      st_reg.cfg.ready_en <= CFG_RST[`ERW_CFG_RDYEN_BIT];
      st_reg.cfg.mand_waits <= CFG_RST[`ERW_CFG_MWAIT_MSB:`ERW_CFG_MWAIT_LSB];
      st_reg.rd_n <= 1'b1;
      st_reg.wr_n <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign pready = st_reg.pready;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign req_ack = st_reg.ack;
  assign req_rdata = st_reg.rdata;
  assign bus_reference_clock = st_reg.refclk;
  assign ext_addr = st_reg.addr;
  assign ext_rd_n = st_reg.rd_n;
  assign ext_wr_n = st_reg.wr_n;
  assign ext_data_out = st_reg.dout;
  assign ext_data_oe = st_reg.doe;

endmodule

// file: src/erw_sync.sv
// three-stage input synchroniser that reports a level once stages two and three agree
module erw_sync
  import erw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } erw_sync_st_t;

  erw_sync_st_t st_reg;
  erw_sync_st_t st_next;

  // shift chain, output follows when the last two stages agree
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.q;

endmodule

// file: tb/erw_ext_dev.sv
// external device model with programmable ready delay
module erw_ext_dev (
  input wire logic bus_reference_clock,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic [23:0] ext_addr,
  input wire logic [15:0] ext_data_out,
  input wire logic dev_pol,
  input wire logic [3:0] lag,
  output logic [15:0] ext_data_in,
  output logic ext_ready,
  output logic [15:0] last_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = '0;
  wire logic busy = !(ext_rd_n && ext_wr_n);
  // reference periods of the running command
  always @(posedge bus_reference_clock)
    cnt <= busy ? cnt + 4'h1 : 4'h0;
  // ready dropped with the strobe, so the next cycle starts inactive
  assign ext_ready = (busy && cnt >= lag) ? dev_pol : !dev_pol;
  // read data inverted once the strobe is gone
  assign ext_data_in = ext_addr[15:0] ^ 16'h5A5A ^ {16{ext_rd_n}};
  // word seen at the end of a write
  always @(posedge ext_wr_n)
    last_wr <= ext_data_out;
endmodule

// file: tb/erw_ready_ctrl_bench.sv
// bench of the ready wait control with an external device model
module erw_ready_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
  logic pready, pslverr, req_ack, bus_reference_clock, ext_rd_n, ext_wr_n;
  logic ext_data_oe, ext_ready, req_valid = 1'h0, req_write = 1'h0, dev_pol = 1'h1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [23:0] req_addr = '0, ext_addr;
  logic [15:0] req_wdata = '0, req_rdata, ext_data_out, ext_data_in, last_wr;
  logic [3:0] lag = '0;
  logic [7:0] cf [7] = '{8'h05, 8'h05, 8'h05, 8'h35, 8'h55, 8'h04, 8'h07};
  logic [3:0] lg [7] = '{4'h1, 4'h2, 4'h3, 4'h1, 4'h1, 4'h2, 4'h2};
  int errors = 0, n_compared = 0, cycles = 0, len, ln [7];
  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;
  erw_ready_ctrl uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ack(req_ack), .req_rdata(req_rdata),
    .bus_reference_clock(bus_reference_clock), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .ext_data_in(ext_data_in), .ext_ready(ext_ready)
  );
  erw_ext_dev dev (
    .bus_reference_clock(bus_reference_clock), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .ext_addr(ext_addr), .ext_data_out(ext_data_out), .dev_pol(dev_pol), .lag(lag),
    .ext_data_in(ext_data_in), .ext_ready(ext_ready), .last_wr(last_wr)
  );
  task test_done;
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    n_compared++;
    if (s !== x)
    begin
      $display("wrong value %s expected %h seen %h", n, x, s);
      errors++;
    end
  endtask
  // one register bus transfer, answer left in q and e
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1)
      @(posedge clk_sys);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // one external cycle; len counts clocks from strobe low to ack
  task cyc(input logic w, input logic [31:0] c, input logic [3:0] k, input logic p);
    apb(1'h1, 12'h000, c);
    lag <= k;
    dev_pol <= p;
    req_write <= w;
    req_addr <= req_addr + 24'h001234;
    req_wdata <= req_wdata + 16'hA5C3;
    req_valid <= 1'h1;
    len = 0;
    @(posedge clk_sys);
    while (ext_rd_n && ext_wr_n)
      @(posedge clk_sys);
    while (req_ack !== 1'h1)
    begin
      len++;
      @(posedge clk_sys);
    end
    req_valid <= 1'h0;
    if (w)
      chk("write data", {16'h0, req_wdata}, {16'h0, last_wr});
    else
      chk("read data", {16'h0, req_addr[15:0] ^ 16'h5A5A}, {16'h0, req_rdata});
  endtask
  // watchdog on the whole run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      test_done;
    end
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'h1;
    apb(1'h0, 12'h000, '0);
    chk("cfg reset", 32'h11, q);
    apb(1'h0, 12'h00C, '0);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'h1, 12'h004, 32'h1);
    chk("read-only error", 32'h1, {31'h0, e});
    for (int i = 0; i < 7; i++)
    begin
      cyc(i[0], {24'h0, cf[i]}, lg[i], i != 5);
      ln[i] = len;
    end
    chk("ready step", 32'h2, ln[1] - ln[0]);
    chk("ready step", 32'h2, ln[2] - ln[1]);
    chk("mandatory step", 32'h4, ln[4] - ln[3]);
    chk("low polarity", ln[1], ln[5]);
    chk("async longer", 32'h1, {31'h0, ln[6] > ln[1]});
    apb(1'h0, 12'h004, '0);
    chk("status", 32'h0007_0400, q);
    apb(1'h0, 12'h008, '0);
    chk("read data register", {16'h0, req_addr[15:0] ^ 16'h5A5A}, q);
    test_done;
  end
endmodule

// file: tb/erw_ready_ctrl_monitor.sv
// port checks of the ready wait control
module erw_ready_ctrl_monitor (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic req_ack,
  input wire logic bus_reference_clock,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic ext_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // strobes, ack and reference clock
  property p_excl; !(!ext_rd_n && !ext_wr_n); endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_ack; ($rose(ext_rd_n) || $rose(ext_wr_n)) |-> ##1 req_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack after strobe end");
  property p_strb; ($fell(ext_rd_n) || $fell(ext_wr_n)) |=> (!ext_rd_n || !ext_wr_n); endproperty
  a_strb: assert property (p_strb) else $error("strobe too short");
  property p_ref; bus_reference_clock |=> !bus_reference_clock; endproperty
  a_ref: assert property (p_ref) else $error("reference clock stuck");
  property p_ref0; !bus_reference_clock |=> bus_reference_clock; endproperty
  a_ref0: assert property (p_ref0) else $error("reference clock stuck low");
  property p_oe; ext_data_oe |-> ext_rd_n; endproperty
  a_oe: assert property (p_oe) else $error("data driven in read");
  // register bus answers
  property p_rdy; pready |-> psel && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside access");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // main scenarios
  c_rd: cover property ($rose(ext_rd_n));
  c_wr: cover property ($rose(ext_wr_n));
  c_err: cover property (pslverr);
endmodule

bind erw_ready_ctrl erw_ready_ctrl_monitor u_mon (.clk_sys(clk_sys), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .req_ack(req_ack),
  .bus_reference_clock(bus_reference_clock), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
  .ext_data_oe(ext_data_oe));
